// file: hbc_pkg.sv
// Constants, field layouts, reset values and state codes of the H-bridge control block.
// Assumes a single 200 MHz clock; every interval is counted in cycles of that clock.
package hbc_pkg;

  // Clock rate and timing
  localparam int CLK_MHZ = 200;
  localparam int TOFF_STEP_US = 20;
  localparam int TOFF_STEP_CYC = TOFF_STEP_US * CLK_MHZ;
  localparam int BLANK_NS = 2000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  // APB map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_THREE = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_FOUR = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;

  // control_three fields
  localparam int BIT_HALF_A_HIZ = 0;
  localparam int BIT_HALF_B_HIZ = 1;
  localparam int BIT_FAULT_CLEAR = 2;

  // control_four fields, two bits wide except the one-bit overcurrent response
  localparam int POS_REG_OFF = 0;
  localparam int POS_TRIP_LVL = 2;
  localparam int POS_TOFF = 4;
  localparam int POS_MODE = 6;
  localparam int BIT_OCP_RESP = 8;

  // Status fields
  localparam int POS_ST_MODE = 0;
  localparam int BIT_ST_OFF_A = 2;
  localparam int BIT_ST_OFF_B = 3;
  localparam int BIT_ST_OCP_A = 4;
  localparam int BIT_ST_OCP_B = 5;
  localparam int BIT_ST_ASLEEP = 6;

  // Control modes
  localparam logic [1:0] MODE_PH_EN = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h1;
  localparam logic [1:0] MODE_INDEP = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;

  // Reset values and fixed settings of the pin-configured variant
  localparam logic [1:0] MODE_RST = MODE_PWM;
  localparam logic [1:0] TOFF_RST = 2'h1;
  localparam logic [1:0] TOFF_HW = 2'h1;
  localparam logic [1:0] TRIP_RST = 2'h0;
  localparam logic [1:0] TRIP_HW = 2'h2;
  localparam logic [1:0] REG_OFF_RST = 2'h0;
  localparam logic HIZ_RST = 1'b0;
  localparam logic OCP_RESP_LATCH = 1'b0;

  // Input synchroniser slots
  localparam int SYNC_N = 9;

  typedef enum logic [3:0] {
    CHOP_IDLE = 4'b0001,
    CHOP_BLANK = 4'b0010,
    CHOP_ARMED = 4'b0100,
    CHOP_OFF = 4'b1000
  } hbc_chop_state_t;

endpackage : hbc_pkg

// file: hbc_chop_if.sv
// Signals between the control top and one half-bridge chopping timer.
// Assumes both ends share sys_clk; all fields are already synchronised.
`timescale 1ns/1ps
interface hbc_chop_if;
  logic reg_en;
  logic drive_on;
  logic trip;
  logic [hbc_pkg::CNT_W-1:0] toff_len;
  logic off_active;

  modport timer (
    input reg_en,
    input drive_on,
    input trip,
    input toff_len,
    output off_active
  );

  modport ctrl (
    output reg_en,
    output drive_on,
    output trip,
    output toff_len,
    input off_active
  );
endinterface : hbc_chop_if

// file: hbc_chop_timer.sv
// Fixed off-time chopping timer for one half-bridge: blanking, then armed, then off time.
// Assumes synchronous inputs from the control top and the synchronised reset.
`timescale 1ns/1ps
module hbc_chop_timer (
  input wire logic clk,
  input wire logic rst_n,
  hbc_chop_if.timer chop
);
  import hbc_pkg::*;

  hbc_chop_state_t state;
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CHOP_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        CHOP_IDLE: begin
          if (chop.reg_en && chop.drive_on) begin
            state <= CHOP_BLANK;
            cnt <= CNT_W'(BLANK_CYC - 1);
          end
        end
        CHOP_BLANK: begin
          if (!chop.reg_en || !chop.drive_on) begin
            state <= CHOP_IDLE;
          end else if (cnt == '0) begin
            state <= CHOP_ARMED;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        CHOP_ARMED: begin
          if (!chop.reg_en || !chop.drive_on) begin
            state <= CHOP_IDLE;
          end else if (chop.trip) begin
            state <= CHOP_OFF;
            cnt <= chop.toff_len - 1'b1;
          end
        end
        CHOP_OFF: begin
          if (!chop.reg_en) begin
            state <= CHOP_IDLE;
          end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (chop.trip) begin
            cnt <= chop.toff_len - 1'b1;
          end else begin
            // Each resumed drive period is blanked again
            state <= CHOP_BLANK;
            cnt <= CNT_W'(BLANK_CYC - 1);
          end
        end
      endcase
    end
  end

  assign chop.off_active = (state == CHOP_OFF);

endmodule : hbc_chop_timer

// file: hbc_top.sv
// Logic core of an H-bridge driver: input decoding, per-half Hi-Z in independent mode, current chopping, OVERCURRENT_PROTECTION.
// Assumes an APB master on sys_clk and asynchronous pins for inputs and comparators.
`timescale 1ns/1ps
module hbc_top #(
  parameter bit HW_VARIANT = 1'b0,
  parameter logic [1:0] HW_MODE = hbc_pkg::MODE_INDEP,
  parameter int TOFF_STEP_CYCLES = hbc_pkg::TOFF_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_power_request_n,
  input wire logic disable_in,
  input wire logic input_a,
  input wire logic input_b,
  input wire logic trip_a_reached,
  input wire logic trip_b_reached,
  input wire logic overcurrent_a,
  input wire logic overcurrent_b,
  input wire logic regulation_off_pin_n,
  output logic half_bridge_a_out,
  output logic half_bridge_a_oe_n,
  output logic half_bridge_b_out,
  output logic half_bridge_b_oe_n,
  output logic [1:0] trip_current
);
  import hbc_pkg::*;

  // Decoded request: {a drives, a level, b drives, b level}
  function automatic logic [3:0] decode_inputs(
    input logic [1:0] mode,
    input logic in_a,
    input logic in_b
  );
    logic [3:0] r;
    r = 4'h0;
    unique case (mode)
      MODE_PH_EN: begin
        if (!in_a) begin
          r = 4'hf;
        end else begin
          r = {1'b1, in_b, 1'b1, ~in_b};
        end
      end
      MODE_PWM: begin
        if (in_a || in_b) begin
          r = {1'b1, in_a, 1'b1, in_b};
        end
      end
      MODE_INDEP: r = {1'b1, in_a, 1'b1, in_b};
      MODE_OFF: r = 4'h0;
    endcase
    return r;
  endfunction : decode_inputs

  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pin synchronisers
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] pin_meta;
  logic [SYNC_N-1:0] pin_s;

  assign pin_raw = {regulation_off_pin_n, overcurrent_b, overcurrent_a, trip_b_reached,
                    trip_a_reached, input_b, input_a, disable_in, low_power_request_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          pin_meta[gi] <= 1'b0;
          pin_s[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic awake_s;
  logic dis_s;
  logic in_a_s;
  logic in_b_s;
  logic trip_a_s;
  logic trip_b_s;
  logic ocp_a_s;
  logic ocp_b_s;
  logic reg_off_pin_s;

  assign awake_s = pin_s[0];
  assign dis_s = pin_s[1];
  assign in_a_s = pin_s[2];
  assign in_b_s = pin_s[3];
  assign trip_a_s = pin_s[4];
  assign trip_b_s = pin_s[5];
  assign ocp_a_s = pin_s[6];
  assign ocp_b_s = pin_s[7];
  assign reg_off_pin_s = pin_s[8];

  // APB slave: one wait state, answer on the second access cycle
  logic apb_take;
  logic wr_take;
  logic addr_ok;

  assign apb_take = psel && penable && pready;
  assign wr_take = apb_take && pwrite;
  assign addr_ok = (paddr == ADDR_CONTROL_THREE) || (paddr == ADDR_CONTROL_FOUR)
                   || (paddr == ADDR_STATUS);

  // Software settings
  logic half_a_force_hiz;
  logic half_b_force_hiz;
  logic [1:0] regulation_off_select;
  logic [1:0] trip_level_select;
  logic [1:0] off_time_select;
  logic [1:0] mode_select;
  logic overcurrent_response_select;
  logic fault_clear;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      half_a_force_hiz <= HIZ_RST;
      half_b_force_hiz <= HIZ_RST;
    end else if (wr_take && (paddr == ADDR_CONTROL_THREE) && !HW_VARIANT) begin
      half_a_force_hiz <= pwdata[BIT_HALF_A_HIZ];
      half_b_force_hiz <= pwdata[BIT_HALF_B_HIZ];
    end
  end

  // Pin variant ignores writes; these registers keep their reset values
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      regulation_off_select <= REG_OFF_RST;
      trip_level_select <= TRIP_RST;
      off_time_select <= TOFF_RST;
      mode_select <= MODE_RST;
      overcurrent_response_select <= OCP_RESP_LATCH;
    end else if (wr_take && (paddr == ADDR_CONTROL_FOUR) && !HW_VARIANT) begin
      regulation_off_select <= pwdata[POS_REG_OFF +: 2];
      trip_level_select <= pwdata[POS_TRIP_LVL +: 2];
      off_time_select <= pwdata[POS_TOFF +: 2];
      mode_select <= pwdata[POS_MODE +: 2];
      overcurrent_response_select <= pwdata[BIT_OCP_RESP];
    end
  end

  assign fault_clear = wr_take && (paddr == ADDR_CONTROL_THREE) && pwdata[BIT_FAULT_CLEAR];

  // Mode latch on the falling edge of the disable input
  logic dis_q;
  logic [1:0] active_mode;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dis_q <= 1'b0;
      active_mode <= MODE_RST;
    end else begin
      dis_q <= dis_s;
      if (HW_VARIANT) begin
        active_mode <= HW_MODE;
      end else if (dis_q && !dis_s) begin
        active_mode <= mode_select;
      end
    end
  end

  logic indep;
  logic asleep;

  assign indep = (active_mode == MODE_INDEP);
  assign asleep = !awake_s || dis_s;

  // Overcurrent latches: set wins over any clear
  logic ocp_lat_a;
  logic ocp_lat_b;
  logic ocp_release_a;
  logic ocp_release_b;
  logic latch_mode;

  // Retry release only once the overcurrent indication has gone
  assign latch_mode = HW_VARIANT || (overcurrent_response_select == OCP_RESP_LATCH);
  assign ocp_release_a = !awake_s || (latch_mode ? fault_clear : !ocp_a_s);
  assign ocp_release_b = !awake_s || (latch_mode ? fault_clear : !ocp_b_s);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ocp_lat_a <= 1'b0;
      ocp_lat_b <= 1'b0;
    end else begin
      if (ocp_a_s) begin
        ocp_lat_a <= 1'b1;
      end else if (ocp_release_a) begin
        ocp_lat_a <= 1'b0;
      end
      if (ocp_b_s) begin
        ocp_lat_b <= 1'b1;
      end else if (ocp_release_b) begin
        ocp_lat_b <= 1'b0;
      end
    end
  end

  // Fault shut-off: per half in independent mode, whole bridge otherwise
  logic shut_a;
  logic shut_b;

  assign shut_a = indep ? ocp_lat_a : (ocp_lat_a || ocp_lat_b);
  assign shut_b = indep ? ocp_lat_b : (ocp_lat_a || ocp_lat_b);

  // Chopping timers, one per half
  logic [3:0] req;
  logic [1:0] reg_off;
  logic [1:0] toff_eff;
  logic [CNT_W-1:0] toff_len;
  logic [1:0] trip_v;
  logic [1:0] drive_v;
  logic [1:0] off_v;

  assign req = decode_inputs(active_mode, in_a_s, in_b_s);
  assign reg_off = HW_VARIANT ? {2{reg_off_pin_s}} : regulation_off_select;
  assign toff_eff = HW_VARIANT ? TOFF_HW : off_time_select;
  assign toff_len = CNT_W'(TOFF_STEP_CYCLES * (int'(toff_eff) + 1));
  assign trip_v = {trip_b_s, trip_a_s};
  assign drive_v = {req[1], req[3]};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_chop
      hbc_chop_if chop_bus ();
      assign chop_bus.reg_en = !reg_off[gi] && !asleep;
      assign chop_bus.drive_on = drive_v[gi] && !asleep;
      assign chop_bus.trip = trip_v[gi];
      assign chop_bus.toff_len = toff_len;
      assign off_v[gi] = chop_bus.off_active;
      hbc_chop_timer u_timer (
        .clk(sys_clk),
        .rst_n(rst_sync_n),
        .chop(chop_bus)
      );
    end
  endgenerate

  // Direction at entry into regulation, for reverse-drive acceptance
  logic chop_any;
  logic chop_q;
  logic entry_fwd;
  logic entry_rev;
  logic req_fwd;
  logic req_rev;
  logic reverse_ok;

  assign chop_any = off_v[0] || off_v[1];
  assign req_fwd = (req == 4'he);
  assign req_rev = (req == 4'hb);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chop_q <= 1'b0;
      entry_fwd <= 1'b0;
      entry_rev <= 1'b0;
    end else begin
      chop_q <= chop_any;
      if (chop_any && !chop_q) begin
        entry_fwd <= req_fwd;
        entry_rev <= req_rev;
      end
    end
  end

  // Opposite direction only counts in the H-bridge modes
  assign reverse_ok = !indep && ((entry_fwd && req_rev) || (entry_rev && req_fwd));

  // Output stage: drive enable and level per half
  logic decay_a;
  logic decay_b;
  logic drv_a;
  logic drv_b;
  logic lvl_a;
  logic lvl_b;

  // Slow decay on both high sides; independent halves chop on their own
  assign decay_a = (indep ? off_v[0] : chop_any) && !reverse_ok;
  assign decay_b = (indep ? off_v[1] : chop_any) && !reverse_ok;

  always_comb begin
    drv_a = req[3];
    lvl_a = req[2];
    drv_b = req[1];
    lvl_b = req[0];
    if (decay_a) begin
      drv_a = 1'b1;
      lvl_a = 1'b1;
    end
    if (decay_b) begin
      drv_b = 1'b1;
      lvl_b = 1'b1;
    end
    if (asleep || shut_a || (indep && half_a_force_hiz)) begin
      drv_a = 1'b0;
      lvl_a = 1'b0;
    end
    if (asleep || shut_b || (indep && half_b_force_hiz)) begin
      drv_b = 1'b0;
      lvl_b = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      half_bridge_a_out <= 1'b0;
      half_bridge_a_oe_n <= 1'b1;
      half_bridge_b_out <= 1'b0;
      half_bridge_b_oe_n <= 1'b1;
      trip_current <= TRIP_RST;
    end else begin
      half_bridge_a_out <= lvl_a;
      half_bridge_a_oe_n <= !drv_a;
      half_bridge_b_out <= lvl_b;
      half_bridge_b_oe_n <= !drv_b;
      trip_current <= HW_VARIANT ? TRIP_HW : trip_level_select;
    end
  end

  // Read data and answer
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0;
    if (paddr == ADDR_CONTROL_THREE) begin
      rd_word[BIT_HALF_A_HIZ] = half_a_force_hiz;
      rd_word[BIT_HALF_B_HIZ] = half_b_force_hiz;
    end else if (paddr == ADDR_CONTROL_FOUR) begin
      rd_word[POS_REG_OFF +: 2] = regulation_off_select;
      rd_word[POS_TRIP_LVL +: 2] = trip_level_select;
      rd_word[POS_TOFF +: 2] = off_time_select;
      rd_word[POS_MODE +: 2] = mode_select;
      rd_word[BIT_OCP_RESP] = overcurrent_response_select;
    end else if (paddr == ADDR_STATUS) begin
      rd_word[POS_ST_MODE +: 2] = active_mode;
      rd_word[BIT_ST_OFF_A] = off_v[0];
      rd_word[BIT_ST_OFF_B] = off_v[1];
      rd_word[BIT_ST_OCP_A] = ocp_lat_a;
      rd_word[BIT_ST_OCP_B] = ocp_lat_b;
      rd_word[BIT_ST_ASLEEP] = asleep;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_word : 32'h0;
    end
  end

endmodule : hbc_top

// file: hbc_top_asserts.sv
// Checker for the H-bridge control top: bus handshake, Hi-Z forcing, trip code.
// Assumes it is bound to hbc_top and sees only that module's ports.
`timescale 1ns/1ps
module hbc_top_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_power_request_n,
  input wire logic disable_in,
  input wire logic overcurrent_a,
  input wire logic overcurrent_b,
  input wire logic half_bridge_a_out,
  input wire logic half_bridge_a_oe_n,
  input wire logic half_bridge_b_out,
  input wire logic half_bridge_b_oe_n,
  input wire logic [1:0] trip_current
);
  import hbc_pkg::*;
  logic acc;
  logic mapped;
  assign acc = psel && penable && pready;
  assign mapped = paddr == ADDR_CONTROL_THREE || paddr == ADDR_CONTROL_FOUR
    || paddr == ADDR_STATUS;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Pins pass two sync flops and an output register, hence four samples;
  // the overcurrent latch adds one more flop, hence five
  a_sleep_hiz:
    assert property (!low_power_request_n [*4] |-> half_bridge_a_oe_n && half_bridge_b_oe_n)
    else $error("sleep did not float both outputs");
  a_disable_hiz:
    assert property (disable_in [*4] |-> half_bridge_a_oe_n && half_bridge_b_oe_n)
    else $error("disable did not float both outputs");
  a_ocp_a_off:
    assert property (overcurrent_a [*5] |-> half_bridge_a_oe_n)
    else $error("overcurrent on half a left it driving");
  a_ocp_b_off:
    assert property (overcurrent_b [*5] |-> half_bridge_b_oe_n)
    else $error("overcurrent on half b left it driving");
  a_trip_code_hold:
    assert property (!(acc && pwrite) ##1 !(acc && pwrite) |=> $stable(trip_current))
    else $error("trip code moved without a write");
  a_unmapped_err:
    assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  a_mapped_ok:
    assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged");
  a_one_wait_state:
    assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  a_rdata_idle:
    assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready cycle");
  cover property (acc && pwrite && paddr == ADDR_CONTROL_FOUR);
  cover property (pslverr);
  cover property (overcurrent_a && half_bridge_a_oe_n && !half_bridge_b_oe_n);
  cover property (half_bridge_a_out && half_bridge_b_out && !half_bridge_b_oe_n);
endmodule : hbc_top_asserts

bind hbc_top hbc_top_asserts u_asserts (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .low_power_request_n, .disable_in, .overcurrent_a,
  .overcurrent_b, .half_bridge_a_out, .half_bridge_a_oe_n, .half_bridge_b_out,
  .half_bridge_b_oe_n, .trip_current);

// file: hbc_host_model.sv
// Host controller model: APB master and logic-input driver.
// Assumes one clock; every change lands by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module hbc_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [hbc_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic low_power_request_n,
  output logic disable_in,
  output logic input_a,
  output logic input_b
);
  import hbc_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    low_power_request_n = 1'b1;
    disable_in = 1'b0;
    input_a = 1'b0;
    input_b = 1'b0;
  end
  // Waits as long as the slave needs; only the bench watchdog ends a stall
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows inverted lines so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic pins(input logic sn, input logic dis, input logic a, input logic b);
    @(posedge clk);
    low_power_request_n <= sn;
    disable_in <= dis;
    input_a <= a;
    input_b <= b;
  endtask : pins
  // Reduced speed alternates drive and brake, never coast
  task automatic drive_brake(input int n);
    repeat (n) begin
      pins(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (20) @(posedge clk);
      pins(1'b1, 1'b0, 1'b1, 1'b1);
      repeat (20) @(posedge clk);
    end
  endtask : drive_brake
endmodule : hbc_host_model

// file: hbc_top_tb.sv
// Self-checking bench for hbc_top with host model, comparator and overcurrent stimulus.
// Assumes the checker and host model files are compiled first.
`timescale 1ns/1ps
module hbc_top_tb;
  import hbc_pkg::*;
  // Short off-time step keeps the run brief; expectations scale with it
  localparam int TSTEP = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic trip_a_reached = 1'b0;
  logic trip_b_reached = 1'b0;
  logic overcurrent_a = 1'b0;
  logic overcurrent_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic low_power_request_n, disable_in, input_a, input_b;
  logic half_bridge_a_out, half_bridge_a_oe_n, half_bridge_b_out, half_bridge_b_oe_n;
  logic [1:0] trip_current;
  int failures = 0;
  int comparisons = 0;
  int seed = 5;
  int v;
  always #2.5 sys_clk = ~sys_clk;
  hbc_host_model host (.clk(sys_clk), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .low_power_request_n, .disable_in, .input_a, .input_b);
  hbc_top #(.TOFF_STEP_CYCLES(TSTEP)) dut (.sys_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .low_power_request_n, .disable_in,
    .input_a, .input_b, .trip_a_reached, .trip_b_reached, .overcurrent_a, .overcurrent_b,
    .regulation_off_pin_n(1'b0), .half_bridge_a_out, .half_bridge_a_oe_n,
    .half_bridge_b_out, .half_bridge_b_oe_n, .trip_current);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string w);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, w, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string w);
    host.xfer(1'b0, a, 32'h0, rd, err);
    check(rd, e, w);
  endtask : rdc
  // Independent-mode reference: any Hi-Z cause wins over the input level
  function automatic logic [3:0] indep(input int sn, dis, a, b, fa, fb);
    int za;
    int zb;
    za = (sn == 0 || dis != 0 || fa != 0);
    zb = (sn == 0 || dis != 0 || fb != 0);
    return {za[0], za == 0 && a != 0, zb[0], zb == 0 && b != 0};
  endfunction : indep
  task automatic see(input logic [3:0] e, input string w);
    check({half_bridge_a_oe_n, half_bridge_a_out, half_bridge_b_oe_n, half_bridge_b_out}, e, w);
  endtask : see
  // Forward drive with the trip high through blanking and one and a half off times of decay; half b rising marks the decay window
  task automatic chop(input int sel);
    int toff;
    int tb;
    int to;
    toff = TSTEP * (sel + 1);
    tb = 0;
    to = 0;
    host.pins(1'b1, 1'b0, 1'b1, 1'b0);
    trip_a_reached <= 1'b1;
    while (half_bridge_b_out !== 1'b1 && tb < 2000) begin
      cyc(1);
      tb++;
    end
    while (half_bridge_b_out === 1'b1 && to < 2000) begin
      cyc(1);
      to++;
      if (to == toff + toff / 2) trip_a_reached <= 1'b0;
    end
    check(tb >= BLANK_CYC && tb <= BLANK_CYC + 8, 1'b1, "blanking");
    check(to >= 2 * toff - 6 && to <= 2 * toff + 6, 1'b1, "off time");
    host.pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(8);
  endtask : chop
  initial begin
    #200000;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    cyc(3);
    check(trip_current, 2'b00, "trip code reset");
    rdc(ADDR_CONTROL_THREE, 32'h0, "ctl3 reset");
    rdc(ADDR_CONTROL_FOUR, 32'h50, "ctl4 reset");
    rdc(12'h00c, 32'h0, "unmapped read");
    check(err, 1'b1, "unmapped error");
    for (int l = 0; l < 4; l++) begin
      wr(ADDR_CONTROL_FOUR, 32'h50 | (l << POS_TRIP_LVL));
      cyc(3);
      check(trip_current, l, "trip code");
    end
    host.drive_brake(2);
    host.pins(1'b1, 1'b0, 1'b0, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONTROL_FOUR, 32'h40 | (s << POS_TOFF));
      chop(s);
    end
    for (int r = 1; r < 4; r++) begin
      wr(ADDR_CONTROL_FOUR, 32'h50 | r);
      host.pins(1'b1, 1'b0, 1'b1, 1'b0);
      trip_a_reached <= 1'b1;
      cyc(BLANK_CYC + 20);
      check(half_bridge_b_out, r == 2, "regulation select");
      trip_a_reached <= 1'b0;
      host.pins(1'b1, 1'b0, 1'b0, 1'b0);
      cyc(8);
    end
    wr(ADDR_CONTROL_FOUR, 32'h50);
    host.pins(1'b1, 1'b0, 1'b1, 1'b0);
    trip_a_reached <= 1'b1;
    cyc(BLANK_CYC + 20);
    check({half_bridge_a_out, half_bridge_b_out}, 2'b11, "slow decay");
    host.pins(1'b1, 1'b0, 1'b0, 1'b1);
    cyc(4);
    see(4'b0001, "reverse drive");
    trip_a_reached <= 1'b0;
    wr(ADDR_CONTROL_FOUR, 32'h90);
    host.xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    check(rd[1:0], MODE_PWM, "mode held");
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(4);
    host.pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(4);
    host.xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    check(rd[1:0], MODE_INDEP, "mode latched");
    repeat (40) begin
      v = $random(seed);
      host.pins(v[3:2] != 0, v[5:4] == 0, v[0], v[1]);
      cyc(4);
      see(indep(v[3:2] != 0, v[5:4] == 0, v[0], v[1], 0, 0), "indep drive");
    end
    for (int f = 1; f < 4; f++) begin
      wr(ADDR_CONTROL_THREE, f);
      host.pins(1'b1, 1'b0, 1'b1, 1'b1);
      cyc(4);
      see(indep(1, 0, 1, 1, f & 1, f >> 1), "force hiz");
      rdc(ADDR_CONTROL_THREE, f, "force bits");
    end
    wr(ADDR_CONTROL_THREE, 32'h0);
    overcurrent_a <= 1'b1;
    cyc(5);
    see(indep(1, 0, 1, 1, 1, 0), "ocp half a");
    overcurrent_a <= 1'b0;
    cyc(4);
    see(indep(1, 0, 1, 1, 1, 0), "ocp latched");
    wr(ADDR_CONTROL_THREE, 32'h1 << BIT_FAULT_CLEAR);
    cyc(4);
    see(indep(1, 0, 1, 1, 0, 0), "fault cleared");
    wr(ADDR_CONTROL_FOUR, 32'h190);
    overcurrent_b <= 1'b1;
    cyc(5);
    see(indep(1, 0, 1, 1, 0, 1), "ocp half b");
    overcurrent_b <= 1'b0;
    cyc(5);
    see(indep(1, 0, 1, 1, 0, 0), "ocp released");
    summarize();
  end
endmodule : hbc_top_tb
